// ==== ari_adc_regs.sv ====
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE_01] Soft reset command restores reset state
// [RULE_02] Start command begins sequence on enabled channels
// [RULE_03] Trigger disabled: only software start works
// [RULE_04] Trigger enabled: selected source starts conversion
// [RULE_05] Only select code 110 picks external pin
// [RULE_06] Resolution bit: zero ten-bit, one eight-bit
// [RULE_07] Sleep bit: zero normal, one auto sleep
// [RULE_08] Conversion clock is master over (field+1)*2
// [RULE_09] Start-up wait is (field+1)*8 conversion clocks
// [RULE_10] Sample-hold lasts (field+1) conversion clocks
// [RULE_11] Channel set register enables written-one channels
// [RULE_12] Channel clear register disables written-one channels
// [RULE_13] Channel status shows enabled set, zero after reset
// [RULE_14] Software keeps channels stable during conversion
// [RULE_15] Eight result words at 0x30 to 0x4C
// [RULE_16] DMA range 0x100-0x124 left undecoded
// [RULE_17] Mode field positions fixed as laid out
// [RULE_18] Sleep: power up, wait, convert, power down
// [RULE_19] Hardware trigger acts on rising edge
// [RULE_20] Channel takes sample-hold plus ten clocks
// [RULE_21] Software start still works with hardware trigger
module ari_adc_regs
    import ari_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              ext_trigger_pin,
    input  wire logic [RES_W-1:0]  cell_result,
    output logic                   cell_power_on,
    output logic                   cell_sampling,
    output logic                   cell_converting,
    output logic      [2:0]        cell_channel,
    output logic                   cell_low_res,
    output logic                   seq_busy
);
    logic [31:0]      mode_r;
    logic [7:0]       chan_en_r;
    logic [7:0]       eoc_r;
    logic [7:0]       ovr_r;
    logic             drdy_r;
    logic             govr_r;
    logic [19:0]      ie_r;
    logic [RES_W-1:0] last_r;
    logic [2:0]       last_ch_r;
    logic [RES_W-1:0] res_r [NCHAN];
    ari_state_t       state_r;
    logic [2:0]       chan_r;
    logic [7:0]       tcnt_r;
    logic [6:0]       div_cnt_r;
    logic             powered_r;
    logic [2:0]       trg_sync_r;
    logic [31:0]      rdata_r;

    // Scan enabled channels upward; 8 means none left
    function automatic logic [3:0] ari_find(input logic [7:0] en, input logic [3:0] from);
        logic [3:0] hit;
        hit = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && (4'(i) >= from)) begin
                hit = 4'(i);
            end
        end
        return hit;
    endfunction

    wire logic [2:0] trg_sel   = mode_r[MR_HW_TRIGGER_SELECT_L+:3];
    wire logic [5:0] div_fld   = mode_r[MR_DIV_L+:6];
    wire logic [4:0] stup_fld  = mode_r[MR_STUP_L+:5];
    wire logic [3:0] sh_fld    = mode_r[MR_SH_L+:4];
    wire logic       sleep_sel = mode_r[MR_SLEEP];

    wire logic wr_cmd  = reg_wr && (reg_addr == OFS_CMD);
    wire logic srst    = wr_cmd && reg_wdata[CMD_SOFT_RESET_CMD];                                   // [RULE_01]
    wire logic sw_go   = wr_cmd && reg_wdata[CMD_START] && !srst;                          // [RULE_02]
    wire logic trg_rise = trg_sync_r[1] && !trg_sync_r[2];                                 // [RULE_19]
    // Reserved select codes have no source behind them
    wire logic hw_go   = mode_r[MR_HW_TRIGGER_ENABLE] && (trg_sel == TRG_EXT_PIN) && trg_rise; // [RULE_03] [RULE_04] [RULE_05]
    wire logic go      = (sw_go || hw_go) && (state_r == ST_IDLE) && (chan_en_r != 8'h00); // [RULE_21]
    wire logic tick    = (state_r != ST_IDLE) && (div_cnt_r == {div_fld, 1'b1});           // [RULE_08]
    wire logic conv_done = (state_r == ST_CONVERT) && tick && (tcnt_r[3:0] == CONV_LAST);  // [RULE_20]
    wire logic [3:0] first_ch = ari_find(chan_en_r, 4'h0);
    wire logic [3:0] next_ch  = ari_find(chan_en_r, {1'b0, chan_r} + 4'h1);
    wire logic seq_end = conv_done && next_ch[3];
    wire logic [7:0] done_vec = conv_done ? (8'h01 << chan_r) : 8'h00;

    wire logic rd_flags = reg_rd && (reg_addr == OFS_FLAGS);
    wire logic rd_last  = reg_rd && (reg_addr == OFS_LAST);
    wire logic rd_res   = reg_rd && (reg_addr >= OFS_RES0) && (reg_addr <= OFS_RES7)
                          && (reg_addr[1:0] == 2'b00);                                     // [RULE_15]
    wire logic [ADDR_W-1:0] res_ofs = reg_addr - OFS_RES0;
    wire logic [2:0] rd_idx = res_ofs[4:2];
    wire logic [7:0] eoc_clr = (rd_res ? (8'h01 << rd_idx) : 8'h00)
                             | (rd_last ? (8'h01 << last_ch_r) : 8'h00);

    // Pin comes from outside; the second and third stages feed the edge detector
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trg_sync_r <= 3'b000;
        end else begin
            trg_sync_r <= {trg_sync_r[1:0], ext_trigger_pin};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= MR_RESET;
        end else if (srst) begin
            mode_r <= MR_RESET;                                                            // [RULE_01]
        end else if (reg_wr && (reg_addr == OFS_MODE)) begin
            mode_r <= reg_wdata & MR_MASK;                                                 // [RULE_17]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_en_r <= 8'h00;
        end else if (srst) begin
            chan_en_r <= 8'h00;
        end else if (reg_wr && (reg_addr == OFS_CH_SET)) begin
            chan_en_r <= chan_en_r | reg_wdata[7:0];                                       // [RULE_11]
        end else if (reg_wr && (reg_addr == OFS_CH_CLR)) begin
            chan_en_r <= chan_en_r & ~reg_wdata[7:0];                                      // [RULE_12]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ie_r <= 20'h0_0000;
        end else if (srst) begin
            ie_r <= 20'h0_0000;
        end else if (reg_wr && (reg_addr == OFS_IE_SET)) begin
            ie_r <= ie_r | reg_wdata[19:0];
        end else if (reg_wr && (reg_addr == OFS_IE_CLR)) begin
            ie_r <= ie_r & ~reg_wdata[19:0];
        end
    end

    // Conversion clock enable; held at zero while idle so each sequence starts aligned
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_r <= 7'h00;
        end else if (srst || (state_r == ST_IDLE) || tick) begin
            div_cnt_r <= 7'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 7'h01;
        end
    end

    // Sequencer; triggers arriving mid-sequence are dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            chan_r  <= 3'h0;
            tcnt_r  <= 8'h00;
        end else if (srst) begin
            state_r <= ST_IDLE;
            chan_r  <= 3'h0;
            tcnt_r  <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    tcnt_r <= 8'h00;
                    if (go) begin
                        chan_r  <= first_ch[2:0];
                        state_r <= powered_r ? ST_SAMPLE : ST_WAKE;                        // [RULE_18]
                    end
                end
                ST_WAKE: begin
                    if (tick) begin
                        if (tcnt_r == {stup_fld, 3'b111}) begin                            // [RULE_09]
                            tcnt_r  <= 8'h00;
                            state_r <= ST_SAMPLE;
                        end else begin
                            tcnt_r <= tcnt_r + 8'h01;
                        end
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (tcnt_r == {4'h0, sh_fld}) begin                                // [RULE_10]
                            tcnt_r  <= 8'h00;
                            state_r <= ST_CONVERT;
                        end else begin
                            tcnt_r <= tcnt_r + 8'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (conv_done) begin                                                   // [RULE_20]
                        tcnt_r <= 8'h00;
                        if (next_ch[3]) begin
                            state_r <= ST_IDLE;
                        end else begin
                            chan_r  <= next_ch[2:0];
                            state_r <= ST_SAMPLE;
                        end
                    end else if (tick) begin
                        tcnt_r <= tcnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Normal mode keeps the cell up after its first wake; sleep drops it per sequence
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            powered_r <= 1'b0;
        end else if (srst) begin
            powered_r <= 1'b0;
        end else if (go) begin
            powered_r <= 1'b1;
        end else if (sleep_sel && (seq_end || (state_r == ST_IDLE))) begin
            powered_r <= 1'b0;                                                             // [RULE_07] [RULE_18]
        end
    end

    // Eight-bit mode reads with the two top bits zero
    wire logic [RES_W-1:0] conv_val = mode_r[MR_LOW_RESOLUTION_SELECT] ? {2'b00, cell_result[7:0]} : cell_result; // [RULE_06]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_r    <= '0;
            last_ch_r <= 3'h0;
        end else if (srst) begin
            last_r    <= '0;
            last_ch_r <= 3'h0;
        end else if (conv_done) begin
            last_r    <= conv_val;
            last_ch_r <= chan_r;
        end
    end

    generate
        for (genvar g = 0; g < NCHAN; g++) begin : g_res
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    res_r[g] <= '0;
                end else if (srst) begin
                    res_r[g] <= '0;
                end else if (done_vec[g] && chan_en_r[g]) begin
                    res_r[g] <= conv_val;                                                  // [RULE_15]
                end
            end
        end
    endgenerate

    // Hardware set wins over a read-side clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eoc_r  <= 8'h00;
            ovr_r  <= 8'h00;
            drdy_r <= 1'b0;
            govr_r <= 1'b0;
        end else if (srst) begin
            eoc_r  <= 8'h00;
            ovr_r  <= 8'h00;
            drdy_r <= 1'b0;
            govr_r <= 1'b0;
        end else begin
            eoc_r  <= ((eoc_r & ~eoc_clr) | done_vec) & chan_en_r;
            ovr_r  <= (rd_flags ? 8'h00 : ovr_r) | (done_vec & eoc_r);
            drdy_r <= (drdy_r && !rd_last) || conv_done;
            govr_r <= (govr_r && !rd_flags) || (conv_done && drdy_r);
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (rd_res) begin
            rd_mux = {22'h00_0000, res_r[rd_idx]};
        end else begin
            case (reg_addr)
                OFS_MODE:    rd_mux = mode_r;
                OFS_CH_STAT: rd_mux = {24'h00_0000, chan_en_r};                            // [RULE_13]
                OFS_FLAGS:   rd_mux = SR_RESET | {14'h0000, govr_r, drdy_r, ovr_r, eoc_r};
                OFS_LAST:    rd_mux = {22'h00_0000, last_r};
                OFS_IE_STAT: rd_mux = {12'h000, ie_r};
                // DMA window and holes read zero
                default:     rd_mux = 32'h0000_0000;                                       // [RULE_16]
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cell_sampling   <= 1'b0;
            cell_converting <= 1'b0;
            cell_channel    <= 3'h0;
            cell_low_res    <= 1'b0;
            seq_busy        <= 1'b0;
        end else begin
            cell_sampling   <= (state_r == ST_SAMPLE);
            cell_converting <= (state_r == ST_CONVERT);
            cell_channel    <= chan_r;
            cell_low_res    <= mode_r[MR_LOW_RESOLUTION_SELECT];
            seq_busy        <= (state_r != ST_IDLE);
        end
    end

    assign reg_rdata     = rdata_r;
    assign cell_power_on = powered_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_SOFT_RESET_CMD: assert property (srst |=> (mode_r == MR_RESET) && (chan_en_r == 8'h00) // [RULE_01]
        && (state_r == ST_IDLE))
        else $error("soft reset did not clear state");
    AST_START: assert property (sw_go && (state_r == ST_IDLE) && (chan_en_r != 8'h00) // [RULE_02]
        |=> state_r != ST_IDLE)
        else $error("start command ignored");
    AST_NOHW: assert property (!mode_r[MR_HW_TRIGGER_ENABLE] && !sw_go && (state_r == ST_IDLE) // [RULE_03]
        |=> state_r == ST_IDLE)
        else $error("sequence began without software start");
    AST_HWTRIG: assert property (hw_go && (state_r == ST_IDLE) && (chan_en_r != 8'h00) && !srst // [RULE_04]
        |=> state_r != ST_IDLE)
        else $error("pin trigger edge ignored");
    AST_RESV: assert property (mode_r[MR_HW_TRIGGER_ENABLE] && (trg_sel != TRG_EXT_PIN) && !sw_go // [RULE_05]
        && (state_r == ST_IDLE) |=> state_r == ST_IDLE)
        else $error("reserved trigger code started a sequence");
    AST_LOW_RESOLUTION_SELECT: assert property (conv_done && mode_r[MR_LOW_RESOLUTION_SELECT] && !srst |=> last_r[9:8] == 2'b00) // [RULE_06]
        else $error("eight-bit result has top bits set");
    AST_SLEEP: assert property (seq_end && sleep_sel && !srst |=> !cell_power_on) // [RULE_07]
        else $error("cell left powered after sleep sequence");
    // A tick that ends the sequence may be followed at once by a new start
    AST_DIV: assert property (tick && !seq_end && !srst |=> (div_cnt_r == 7'h00) // [RULE_08]
        ##1 ((div_cnt_r == 7'h01) || (state_r == ST_IDLE)))
        else $error("divider did not restart after tick");
    AST_STUP: assert property ((state_r == ST_SAMPLE) && ($past(state_r) == ST_WAKE) // [RULE_09]
        |-> $past(tcnt_r) == {$past(stup_fld), 3'b111})
        else $error("start-up wait wrong length");
    AST_SH: assert property ((state_r == ST_CONVERT) && ($past(state_r) == ST_SAMPLE) // [RULE_10]
        |-> $past(tcnt_r) == {4'h0, $past(sh_fld)})
        else $error("sample-hold wrong length");
    AST_CHSET: assert property (reg_wr && (reg_addr == OFS_CH_SET) && !srst // [RULE_11]
        |=> (chan_en_r & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
        else $error("channel not enabled");
    AST_CHCLR: assert property (reg_wr && (reg_addr == OFS_CH_CLR) && !srst // [RULE_12]
        |=> (chan_en_r & $past(reg_wdata[7:0])) == 8'h00)
        else $error("channel not disabled");
    AST_CHSR: assert property (reg_rd && (reg_addr == OFS_CH_STAT) // [RULE_13]
        |=> reg_rdata == {24'h00_0000, $past(chan_en_r)})
        else $error("channel status mismatch");
    AST_DMA: assert property (reg_rd && (reg_addr >= OFS_DMA_LO) && (reg_addr <= OFS_DMA_HI) // [RULE_16]
        |=> reg_rdata == 32'h0000_0000)
        else $error("DMA window decoded");
    AST_CONV: assert property (($past(state_r) == ST_CONVERT) && (state_r != ST_CONVERT) && !$past(srst) // [RULE_20]
        |-> $past(tcnt_r[3:0]) == CONV_LAST)
        else $error("conversion not ten clocks");

    COV_SW_SEQ: cover property (sw_go && (state_r == ST_IDLE) ##[1:1000] seq_end);
    COV_HW_SEQ: cover property (hw_go && (state_r == ST_IDLE) && (chan_en_r != 8'h00));
    COV_OVR:    cover property (conv_done && (eoc_r != 8'h00) && drdy_r);
    COV_SLEEP:  cover property (seq_end && sleep_sel);
endmodule
`default_nettype wire

// ==== ari_pkg.sv ====
`default_nettype none
package ari_pkg;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned NCHAN       = 8;
    localparam int unsigned RES_W       = 10;
    // Byte offsets
    localparam logic [11:0] OFS_CMD     = 12'h000;
    localparam logic [11:0] OFS_MODE    = 12'h004;
    localparam logic [11:0] OFS_CH_SET  = 12'h010;
    localparam logic [11:0] OFS_CH_CLR  = 12'h014;
    localparam logic [11:0] OFS_CH_STAT = 12'h018;
    localparam logic [11:0] OFS_FLAGS   = 12'h01c;
    localparam logic [11:0] OFS_LAST    = 12'h020;
    localparam logic [11:0] OFS_IE_SET  = 12'h024;
    localparam logic [11:0] OFS_IE_CLR  = 12'h028;
    localparam logic [11:0] OFS_IE_STAT = 12'h02c;
    localparam logic [11:0] OFS_RES0    = 12'h030;
    localparam logic [11:0] OFS_RES7    = 12'h04c;
    localparam logic [11:0] OFS_DMA_LO  = 12'h100;
    localparam logic [11:0] OFS_DMA_HI  = 12'h124;
    // Command bits
    localparam int unsigned CMD_SOFT_RESET_CMD   = 0;
    localparam int unsigned CMD_START   = 1;
    // Mode register fields
    localparam int unsigned MR_HW_TRIGGER_ENABLE    = 0;
    localparam int unsigned MR_HW_TRIGGER_SELECT_L = 1;
    localparam int unsigned MR_LOW_RESOLUTION_SELECT   = 4;
    localparam int unsigned MR_SLEEP    = 5;
    localparam int unsigned MR_DIV_L    = 8;
    localparam int unsigned MR_STUP_L   = 16;
    localparam int unsigned MR_SH_L     = 24;
    localparam logic [31:0] MR_MASK     = 32'h0f1f_3f3f;
    localparam logic [31:0] MR_RESET    = 32'h0000_0000;
    localparam logic [2:0]  TRG_EXT_PIN = 3'b110;
    // Flag register layout
    localparam int unsigned SR_OVR_L    = 8;
    localparam int unsigned SR_DRDY     = 16;
    localparam int unsigned SR_GOVR     = 17;
    localparam logic [31:0] SR_RESET    = 32'h000c_0000;
    localparam logic [31:0] IE_MASK     = 32'h000f_ffff;
    // Timing counts in conversion clock periods
    localparam int unsigned STARTUP_MULT = 8;
    localparam logic [3:0]  CONV_LAST    = 4'h9;
    typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_SAMPLE, ST_CONVERT} ari_state_t;
endpackage
`default_nettype wire

// ==== ari_pkg_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== ari_cell_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ari_cell_model
    import ari_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [2:0]       cell_channel,
    input  wire logic             cell_converting,
    output var  logic             ext_trigger_pin,
    output logic      [RES_W-1:0] cell_result
);
    logic [RES_W-1:0] val;
    initial ext_trigger_pin = 1'b0;
    assign val = 10'h155 + 10'(cell_channel) * 10'h049;
    // Outside conversion the code is inverted so a stale sample shows up
    assign cell_result = cell_converting ? val : ~val;
    // One clean rising edge per call, held long enough for the synchroniser
    task automatic pulse();
        @(posedge clk);
        ext_trigger_pin <= 1'b1;
        repeat (4) @(posedge clk);
        ext_trigger_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb_adc_register_interface.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_adc_register_interface
    import ari_pkg::*;
;
    logic              clk       = 1'b0;
    logic              resetn    = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [31:0]       reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    wire logic [31:0]  reg_rdata;
    wire logic         ext_trigger_pin;
    wire logic [9:0]   cell_result;
    wire logic         cell_power_on;
    wire logic         cell_sampling;
    wire logic         cell_converting;
    wire logic [2:0]   cell_channel;
    wire logic         cell_low_res;
    wire logic         seq_busy;
    int                fails       = 0;
    int                comparisons = 0;
    int                cycles      = 0;
    int                seed        = 32'h6a1f4c28;
    int                l1, l2, l3, l4, l5, l6, nch, dv, sh, st, s0;
    int                smp         = 0;
    logic [7:0]        mask;
    logic [31:0]       q;
    logic [11:0]       ra [11] = '{12'h004, 12'h018, 12'h01c, 12'h020, 12'h02c, 12'h030,
                                   12'h034, 12'h04c, 12'h008, 12'h100, 12'h124};

    ari_adc_regs u_ari_adc_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin),
        .cell_result(cell_result), .cell_power_on(cell_power_on), .cell_sampling(cell_sampling),
        .cell_converting(cell_converting), .cell_channel(cell_channel), .cell_low_res(cell_low_res),
        .seq_busy(seq_busy));
    ari_cell_model u_ari_cell_model (.clk(clk), .cell_channel(cell_channel),
        .cell_converting(cell_converting), .ext_trigger_pin(ext_trigger_pin), .cell_result(cell_result));

    always #25 clk = ~clk;

    task automatic close_out();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run is a few thousand cycles; this ceiling only catches a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cell_sampling === 1'b1) begin
            smp <= smp + 1;
        end
        if (cycles == 60000) begin
            fails = fails + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            fails++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // Length of the busy window, zero if no sequence begins
    task automatic go(output int len);
        int n;
        n   = 0;
        len = 0;
        while (seq_busy !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1 n++;
        end
        while (seq_busy === 1'b1 && len < 5000) begin
            @(posedge clk);
            #1 len++;
        end
    endtask

    function automatic logic [31:0] mr(int te, int ts, int lr, int sl, int d, int s, int h);
        return 32'((te << MR_HW_TRIGGER_ENABLE) | (ts << MR_HW_TRIGGER_SELECT_L) | (lr << MR_LOW_RESOLUTION_SELECT) | (sl << MR_SLEEP) |
                   (d << MR_DIV_L) | (s << MR_STUP_L) | (h << MR_SH_L));
    endfunction

    function automatic logic [31:0] cv(int k, int lr);
        logic [9:0] v;
        v = 10'(10'h155 + k * 73);
        return lr ? {24'h0, v[7:0]} : {22'h0, v};
    endfunction

    // Expected words queued per channel, drained in address order
    task automatic res_chk(input int lr);
        logic [31:0] expq [$];
        for (int k = 0; k < 8; k++) begin
            expq.push_back(mask[k] ? cv(k, lr) : 32'h0000_0000);
        end
        for (int k = 0; k < 8; k++) begin
            rd_chk(12'(OFS_RES0 + 4 * k), expq.pop_front());
        end
        rd_chk(OFS_LAST, cv(7, lr));
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rd_chk(ra[i], (ra[i] == OFS_FLAGS) ? SR_RESET : 32'h0000_0000);
        end
        q = ($random(seed) & 32'hffff_fff1) | 32'h0000_000c;
        wr(OFS_MODE, q);
        rd_chk(OFS_MODE, q & MR_MASK);
        wr(OFS_CMD, 32'h0000_0002);
        go(l1);
        chk(l1, 0);
        wr(OFS_CH_STAT, 32'hffff_ffff);
        wr(OFS_CH_SET, 32'h0000_000f);
        wr(OFS_CH_CLR, 32'h0000_0005);
        rd_chk(OFS_CH_STAT, 32'h0000_000a);
        wr(OFS_CH_SET, 32'h0000_0030);
        rd_chk(OFS_CH_STAT, 32'h0000_003a);
        wr(OFS_CH_CLR, 32'h0000_00ff);
        rd_chk(OFS_CH_STAT, 32'h0000_0000);
        // Channels held steady while sequences run
        mask = 8'($random(seed)) | 8'h80;
        nch  = $countones(mask);
        dv   = $unsigned($random(seed)) % 2;
        sh   = $unsigned($random(seed)) % 4;
        st   = $unsigned($random(seed)) % 4;
        wr(OFS_CH_SET, {24'h0, mask});
        rd_chk(OFS_CH_STAT, {24'h0, mask});
        wr(OFS_MODE, mr(0, 0, 0, 0, dv, st, sh));
        wr(OFS_CMD, 32'h0000_0002);
        go(l1);
        rd_chk(OFS_FLAGS, SR_RESET | 32'h0001_0000 | (nch > 1 ? 32'h0002_0000 : 32'h0) | {24'h0, mask});
        s0 = smp;
        wr(OFS_CMD, 32'h0000_0002);
        go(l2);
        chk(32'(l1 - l2), 32'((st + 1) * 8 * (dv + 1) * 2));
        chk(32'(smp - s0), 32'(nch * (sh + 1) * (dv + 1) * 2));
        chk({31'h0, cell_power_on}, 32'h0000_0001);
        rd_chk(OFS_FLAGS, SR_RESET | 32'h0003_0000 | {16'h0, mask, mask});
        res_chk(0);
        wr(OFS_MODE, mr(0, 0, 1, 0, dv, st, sh + 2));
        wr(OFS_CMD, 32'h0000_0002);
        go(l3);
        chk(32'(l3 - l2), 32'(nch * 2 * (dv + 1) * 2));
        chk({31'h0, cell_low_res}, 32'h0000_0001);
        res_chk(1);
        wr(OFS_MODE, mr(0, 0, 1, 0, dv + 1, st, sh + 2));
        wr(OFS_CMD, 32'h0000_0002);
        go(l4);
        chk(32'(l4 - l3), 32'(nch * (sh + 3 + 10) * 2));
        wr(OFS_MODE, mr(0, 0, 0, 1, dv, st, sh));
        wr(OFS_CMD, 32'h0000_0002);
        go(l5);
        chk(32'(l5), 32'(l1));
        chk({31'h0, cell_power_on}, 32'h0000_0000);
        wr(OFS_CMD, 32'h0000_0002);
        go(l6);
        chk(32'(l6), 32'(l1));
        for (int c = 0; c < 8; c++) begin
            wr(OFS_MODE, mr(1, c, 0, 0, 0, 0, 0));
            u_ari_cell_model.pulse();
            go(l1);
            chk(32'(l1 != 0), 32'(c == 6));
        end
        wr(OFS_MODE, mr(0, 6, 0, 0, 0, 0, 0));
        u_ari_cell_model.pulse();
        go(l1);
        chk(32'(l1), 0);
        wr(OFS_MODE, mr(1, 6, 0, 0, 0, 0, 0));
        wr(OFS_CMD, 32'h0000_0002);
        go(l1);
        chk(32'(l1 != 0), 32'h0000_0001);
        wr(OFS_CMD, 32'h0000_0003);
        rd_chk(OFS_MODE, MR_RESET);
        rd_chk(OFS_CH_STAT, 32'h0000_0000);
        rd_chk(OFS_FLAGS, SR_RESET);
        rd_chk(OFS_RES7, 32'h0000_0000);
        wr(OFS_CMD, 32'h0000_0002);
        go(l1);
        chk(32'(l1), 0);
        close_out();
    end
endmodule
`default_nettype wire
